/* File: hdl/rtcp_pkg.sv */
// Purpose: Shared constants and types for the countdown timer and prescaler.
// Assumes: One 50 MHz system clock; the oscillator rate is synthesised by a phase accumulator.
// Notes: Register offsets are byte addresses of the serial register map.

package rtcp_pkg;

    // ------------------------------------------------------------------
    // Clock and oscillator
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam longint CLK_HZ = 64'd1_000_000_000 / CLK_PERIOD_NS;
    localparam longint OSC_HZ = 64'd32768;
    localparam int PHASE_W = 32;
    localparam logic [PHASE_W-1:0] OSC_PHASE_INC =
        PHASE_W'(((64'd1 << PHASE_W) * OSC_HZ + CLK_HZ / 2) / CLK_HZ);

    // ------------------------------------------------------------------
    // Prescaler layout (F0 is bit 0)
    // ------------------------------------------------------------------
    localparam int PRE_W = 15;
    localparam int PRE_LOW_W = 9;
    localparam int PRE_HALT_LSB = 2;
    localparam int TAP_4096 = 2;
    localparam int TAP_1024 = 4;
    localparam int TAP_32 = 9;
    localparam int TAP_1HZ = 14;
    localparam int MIN_DIV = 60;
    localparam int MIN_W = 6;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL1 = 4'h0;
    localparam logic [3:0] ADDR_CTRL2 = 4'h1;
    localparam logic [3:0] ADDR_CFG = 4'hE;
    localparam logic [3:0] ADDR_VALUE = 4'hF;

    localparam int CTRL1_TEST_BIT = 7;
    localparam int CTRL1_HALT_BIT = 5;
    localparam int CTRL2_PULSE_BIT = 4;
    localparam int CTRL2_DONE_BIT = 2;
    localparam int CTRL2_IRQEN_BIT = 0;
    localparam int CFG_RUN_BIT = 7;

    localparam logic [1:0] SRC_4096 = 2'h0;
    localparam logic [1:0] SRC_64 = 2'h1;
    localparam logic [1:0] SRC_1 = 2'h2;
    localparam logic [1:0] SRC_MIN = 2'h3;
    localparam logic [1:0] CFG_SRC_RESET = SRC_MIN;
    localparam logic CFG_RUN_RESET = 1'b0;
    localparam logic [7:0] VALUE_RESET = 8'h00;

    localparam logic [1:0] CLKSEL_32K = 2'h0;
    localparam logic [1:0] CLKSEL_1024 = 2'h1;
    localparam logic [1:0] CLKSEL_32 = 2'h2;
    localparam logic [1:0] CLKSEL_1 = 2'h3;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wrStb;
        logic [3:0] addr;
        logic [7:0] wrData;
    } rtcp_reg_req_t;

    typedef struct packed {
        logic [PHASE_W-1:0] phase;
        logic [PRE_W-1:0] pre;
        logic [MIN_W-1:0] minCnt;
        logic [7:0] count;
        logic [7:0] reload;
        logic run;
        logic [1:0] src;
        logic test;
        logic halt;
        logic pulseSel;
        logic irqEn;
        logic done;
        logic pulse;
        logic irqOe;
        logic secTick;
        logic clkPinOut;
        logic clkPinOe;
        logic [7:0] rdData;
    } rtcp_state_t;

endpackage : rtcp_pkg

/* File: hdl/rtcp_sync_rise.sv */
// Purpose: Two-stage synchroniser with rising-edge pulse for an asynchronous pin.
// Assumes: Pin pulses are much longer than two system clock periods.
// Notes: Edge pulse lags the pin by three clock edges.

`timescale 1ns/1ps

module rtcp_sync_rise (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Pin side
    input wire logic pinIn,
    // Synchronised side
    output logic level,
    output logic rise
);

    logic meta;
    logic prev;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= 1'b0;
            level <= 1'b0;
            prev <= 1'b0;
            rise <= 1'b0;
        end else begin
            meta <= pinIn;
            level <= meta;
            prev <= level;
            rise <= level & ~prev;
        end
    end

endmodule // rtcp_sync_rise

/* File: hdl/rtcp_timer.sv */
// Purpose: Countdown timer, prescaler and halt/test control of the clock block.
// Assumes: Register requests come from the serial decoder on the same clock.
// Notes: Read data appears one cycle after the address is presented.

`timescale 1ns/1ps

// Function
// - Eight-bit down-counter, loaded by software, decrements on each source tick.
// - Source select bits 1:0 pick 4096, 64, 1 or 1/60 Hz; reset 11.
// - Config bit 7 enables the counter; disabled after reset.
// - Completion of each countdown period sets the done flag.
// - Done flag stays set until host writes zero to it.
// - Interrupt enabled: pulse per period or level following done flag.
// - Value register reads return the live count, never frozen.
// - Any value 00h to FFh loads; period is value over source rate, except that 00h never completes.
// - Test bit turns clock-output pin into input replacing 64 Hz.
// - In test mode six stages divide 64 pin edges into one second.
// - Halt bit holds prescaler stages F2 to F14 at zero until written back to zero.
// - After halt release in test mode, first second after 32 edges.
// - Test mode entry is unsynchronised; prescaler state is unknown then.
// - Halt holds stages F2 to F14 reset; no one-second ticks.
// - Halt keeps 32.768 kHz output, suppresses 1.024 kHz, 32 Hz, 1 Hz.
// - Stages F0 and F1 ignore halt, giving restart jitter.
// - Time increments on each rising edge of stage F14.
// - Stage F0 advances at the 32.768 kHz oscillator rate.
// - Reset clears config bit 7 and sets bits 1:0.
module rtcp_timer #(
    parameter longint CLK_HZ = rtcp_pkg::CLK_HZ
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Register access from the serial decoder
    input wire rtcp_pkg::rtcp_reg_req_t regReq,
    output logic [7:0] regRdData,
    // Clock-output selection from its own control register
    input wire logic clkOutEnable,
    input wire logic [1:0] clkOutSel,
    // Clock-output pin, also test tick input
    input wire logic clkPinIn,
    output logic clkPinOut,
    output logic clkPinOe,
    // Open-drain interrupt pin
    output logic irqPinOut,
    output logic irqPinOe,
    // Status toward the calendar counters
    output logic secTick,
    output logic countdownDone
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    localparam int PW = rtcp_pkg::PHASE_W;
    // Phase step follows this instance's clock, not the package default
    localparam logic [PW-1:0] PHASE_INC =
        PW'(((64'd1 << PW) * rtcp_pkg::OSC_HZ + CLK_HZ / 2) / CLK_HZ);

    // Below four clocks per oscillator tick the 4096 Hz stage can skip edges
    if (CLK_HZ < 4 * rtcp_pkg::OSC_HZ) begin : g_clk_check
        $error("rtcp_timer: system clock too slow for the oscillator tick");
    end

    // ------------------------------------------------------------------
    // State and combinational signals
    // ------------------------------------------------------------------
    rtcp_pkg::rtcp_state_t s;
    rtcp_pkg::rtcp_state_t next_s;
    logic extRise;
    logic oscTick;
    logic carry64;
    logic ev64;
    logic tick4k;
    logic tick64;
    logic tick1;
    logic tickMin;
    logic srcTick;
    logic doneEv;
    logic wrCtrl1;
    logic wrCtrl2;
    logic wrCfg;
    logic wrValue;
    logic [rtcp_pkg::PHASE_W:0] phaseSum;
    logic [rtcp_pkg::PRE_LOW_W:0] lowSum;

    rtcp_sync_rise u_ext_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pinIn(clkPinIn),
        .level(),
        .rise(extRise)
    );

    assign wrCtrl1 = regReq.wrStb && (regReq.addr == rtcp_pkg::ADDR_CTRL1);
    assign wrCtrl2 = regReq.wrStb && (regReq.addr == rtcp_pkg::ADDR_CTRL2);
    assign wrCfg = regReq.wrStb && (regReq.addr == rtcp_pkg::ADDR_CFG);
    assign wrValue = regReq.wrStb && (regReq.addr == rtcp_pkg::ADDR_VALUE);

    always_comb begin
        next_s = s;

        // --------------------------------------------------------------
        // Prescaler
        // --------------------------------------------------------------
        phaseSum = {1'b0, s.phase} + {1'b0, PHASE_INC};
        next_s.phase = phaseSum[rtcp_pkg::PHASE_W-1:0];
        oscTick = phaseSum[rtcp_pkg::PHASE_W];
        lowSum = {1'b0, s.pre[rtcp_pkg::PRE_LOW_W-1:0]} + {{rtcp_pkg::PRE_LOW_W{1'b0}}, oscTick};
        next_s.pre[rtcp_pkg::PRE_LOW_W-1:0] = lowSum[rtcp_pkg::PRE_LOW_W-1:0];
        carry64 = lowSum[rtcp_pkg::PRE_LOW_W];
        // Pin edges take over the 64 Hz stage; no alignment on entry
        ev64 = s.test ? extRise : carry64;
        next_s.pre[rtcp_pkg::PRE_W-1:rtcp_pkg::PRE_LOW_W] =
            s.pre[rtcp_pkg::PRE_W-1:rtcp_pkg::PRE_LOW_W] + {5'h00, ev64};
        if (s.halt) begin
            // F0 and F1 keep running, hence the restart jitter
            next_s.pre[rtcp_pkg::PRE_W-1:rtcp_pkg::PRE_HALT_LSB] = '0;
        end
        tick4k = ~s.pre[rtcp_pkg::TAP_4096] & next_s.pre[rtcp_pkg::TAP_4096];
        tick64 = ev64 & ~s.halt;
        tick1 = ~s.pre[rtcp_pkg::TAP_1HZ] & next_s.pre[rtcp_pkg::TAP_1HZ];
        next_s.secTick = tick1;
        tickMin = 1'b0;
        if (tick1) begin
            if (s.minCnt == 6'(rtcp_pkg::MIN_DIV - 1)) begin
                next_s.minCnt = '0;
                tickMin = 1'b1;
            end else begin
                next_s.minCnt = s.minCnt + 6'h01;
            end
        end

        // --------------------------------------------------------------
        // Countdown
        // --------------------------------------------------------------
        unique case (s.src)
            rtcp_pkg::SRC_4096: srcTick = tick4k;
            rtcp_pkg::SRC_64: srcTick = tick64;
            rtcp_pkg::SRC_1: srcTick = tick1;
            rtcp_pkg::SRC_MIN: srcTick = tickMin;
        endcase
        doneEv = 1'b0;
        if (s.run && srcTick) begin
            if (s.count == 8'h01) begin
                next_s.count = s.reload;
                doneEv = 1'b1;
            end else if (s.count == 8'h00) begin
                next_s.count = s.reload;
            end else begin
                next_s.count = s.count - 8'h01;
            end
        end
        if (doneEv) begin
            next_s.pulse = 1'b1;
        end else if (srcTick) begin
            next_s.pulse = 1'b0;
        end

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (wrValue) begin
            next_s.reload = regReq.wrData;
            next_s.count = regReq.wrData;
        end
        if (wrCfg) begin
            next_s.run = regReq.wrData[rtcp_pkg::CFG_RUN_BIT];
            next_s.src = regReq.wrData[1:0];
        end
        if (wrCtrl1) begin
            next_s.test = regReq.wrData[rtcp_pkg::CTRL1_TEST_BIT];
            next_s.halt = regReq.wrData[rtcp_pkg::CTRL1_HALT_BIT];
        end
        if (wrCtrl2) begin
            next_s.pulseSel = regReq.wrData[rtcp_pkg::CTRL2_PULSE_BIT];
            next_s.irqEn = regReq.wrData[rtcp_pkg::CTRL2_IRQEN_BIT];
            if (!regReq.wrData[rtcp_pkg::CTRL2_DONE_BIT]) begin
                next_s.done = 1'b0;
            end
        end
        // Set after clear so a same-cycle completion is not lost
        if (doneEv) begin
            next_s.done = 1'b1;
        end

        // --------------------------------------------------------------
        // Pins and read-back
        // --------------------------------------------------------------
        next_s.irqOe = next_s.irqEn && (next_s.pulseSel ? next_s.pulse : next_s.done);
        unique case (clkOutSel)
            rtcp_pkg::CLKSEL_32K: next_s.clkPinOut = s.phase[rtcp_pkg::PHASE_W-1];
            rtcp_pkg::CLKSEL_1024: next_s.clkPinOut = s.pre[rtcp_pkg::TAP_1024];
            rtcp_pkg::CLKSEL_32: next_s.clkPinOut = s.pre[rtcp_pkg::TAP_32];
            rtcp_pkg::CLKSEL_1: next_s.clkPinOut = s.pre[rtcp_pkg::TAP_1HZ];
        endcase
        next_s.clkPinOe = clkOutEnable && !next_s.test;
        next_s.rdData = 8'h00;
        if (regReq.addr == rtcp_pkg::ADDR_CTRL1) begin
            next_s.rdData[rtcp_pkg::CTRL1_TEST_BIT] = s.test;
            next_s.rdData[rtcp_pkg::CTRL1_HALT_BIT] = s.halt;
        end else if (regReq.addr == rtcp_pkg::ADDR_CTRL2) begin
            next_s.rdData[rtcp_pkg::CTRL2_PULSE_BIT] = s.pulseSel;
            next_s.rdData[rtcp_pkg::CTRL2_DONE_BIT] = s.done;
            next_s.rdData[rtcp_pkg::CTRL2_IRQEN_BIT] = s.irqEn;
        end else if (regReq.addr == rtcp_pkg::ADDR_CFG) begin
            next_s.rdData[rtcp_pkg::CFG_RUN_BIT] = s.run;
            next_s.rdData[1:0] = s.src;
        end else if (regReq.addr == rtcp_pkg::ADDR_VALUE) begin
            // Live count; the host must compare two reads itself
            next_s.rdData = s.count;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s <= '0;
            s.run <= rtcp_pkg::CFG_RUN_RESET;
            s.src <= rtcp_pkg::CFG_SRC_RESET;
            s.count <= rtcp_pkg::VALUE_RESET;
            s.reload <= rtcp_pkg::VALUE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign regRdData = s.rdData;
    assign clkPinOut = s.clkPinOut;
    assign clkPinOe = s.clkPinOe;
    assign irqPinOut = 1'b0;
    assign irqPinOe = s.irqOe;
    assign secTick = s.secTick;
    assign countdownDone = s.done;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_count_decrement: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s.run && srcTick && (s.count > 8'h01) && !wrValue |=> s.count == $past(s.count) - 8'h01)
        else $error("countdown did not decrement by one");

    a_reload_wrap: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s.run && srcTick && (s.count == 8'h01) && !wrValue
        |=> (s.count == $past(s.reload)) && s.done)
        else $error("countdown did not reload at zero");

    a_done_sticky: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s.done && !(wrCtrl2 && !regReq.wrData[rtcp_pkg::CTRL2_DONE_BIT]) |=> s.done)
        else $error("done flag cleared without a host write");

    a_done_set: assert property (
        @(posedge mclk) disable iff (sys_rst)
        doneEv |=> s.done ##1 (!s.pulseSel || !s.irqEn || irqPinOe))
        else $error("completion did not set the done flag");

    a_level_irq: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s.irqEn && !s.pulseSel && s.done && $past(s.done) |-> irqPinOe && !irqPinOut)
        else $error("level interrupt not following done flag");

    a_pulse_release: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s.pulse && srcTick && !doneEv |=> !s.pulse && !(s.pulseSel && irqPinOe))
        else $error("pulsed interrupt held past one source period");

    a_halt_clears: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s.halt |=> s.pre[rtcp_pkg::PRE_W-1:rtcp_pkg::PRE_HALT_LSB] == '0)
        else $error("prescaler upper stages not held at zero");

    a_halt_no_sec: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s.halt && $past(s.halt) |-> !secTick)
        else $error("second tick produced while halted");

    a_test_pin_input: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s.test |-> !clkPinOe)
        else $error("clock-output pin driven in test mode");

    a_config_write: assert property (
        @(posedge mclk) disable iff (sys_rst)
        wrCfg |=> (s.src == $past(regReq.wrData[1:0]))
                  && (s.run == $past(regReq.wrData[rtcp_pkg::CFG_RUN_BIT])))
        else $error("configuration write not taken");

    a_done_set_wins: assert property (
        @(posedge mclk) disable iff (sys_rst)
        doneEv && wrCtrl2 && !regReq.wrData[rtcp_pkg::CTRL2_DONE_BIT] |=> s.done)
        else $error("same-cycle clear beat a countdown completion");

    a_sec_single: assert property (
        @(posedge mclk) disable iff (sys_rst)
        secTick |=> !secTick)
        else $error("second tick longer than one cycle");

    a_clock_output_pin_halted: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $past(s.halt, 2) && ($past(clkOutSel) != rtcp_pkg::CLKSEL_32K) |-> !clkPinOut)
        else $error("divided clock output not suppressed while halted");

    a_ext_count: assert property (
        @(posedge mclk) disable iff (sys_rst)
        s.test && !s.halt && extRise
        |=> s.pre[rtcp_pkg::PRE_W-1:rtcp_pkg::PRE_LOW_W]
            == $past(s.pre[rtcp_pkg::PRE_W-1:rtcp_pkg::PRE_LOW_W]) + 6'h01)
        else $error("pin edge not counted by the upper stages");

endmodule // rtcp_timer

/* File: sim/rtcp_host.sv */
// Purpose: Host model: register bytes and test ticks on the clock-output pin.
// Assumes: Inputs change at falling mclk; one byte per strobe.
// Notes: Released write data is inverted so stale bytes never pass.

`timescale 1ns/1ps

module rtcp_host (
    // Clock
    input wire logic mclk,
    // Register side
    output rtcp_pkg::rtcp_reg_req_t regReq,
    output logic rdTake,
    // Test tick source
    output logic extClk
);
    initial begin
        regReq = '0;
        rdTake = 1'b0;
        extClk = 1'b0;
    end

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        regReq = '{wrStb: 1'b1, addr: a, wrData: d};
        @(negedge mclk);
        regReq.wrStb = 1'b0;
        regReq.wrData = ~d;
    endtask

    // Address held two edges; rdTake marks the settled answer
    task automatic rd(input logic [3:0] a);
        @(negedge mclk);
        regReq.addr = a;
        @(negedge mclk);
        rdTake = 1'b1;
        @(negedge mclk);
        rdTake = 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Pin ticks
    // ------------------------------------------------------------------
    // High 16 cycles meets the 300 ns minimum width
    task automatic ticks(input int n, input int lowLen);
        repeat (n) begin
            @(negedge mclk);
            extClk = 1'b1;
            repeat (16) @(negedge mclk);
            extClk = 1'b0;
            repeat (lowLen) @(negedge mclk);
        end
    endtask
endmodule // rtcp_host

/* File: sim/rtcp_timer_test.sv */
// Purpose: Self-checking bench for the countdown timer and prescaler.
// Assumes: CLK_HZ lowered so one oscillator tick spans four clocks.
// Notes: Reads are checked from a queue by a monitor process.

`timescale 1ns/1ps

module rtcp_timer_test;
    typedef struct packed {
        logic [7:0] d;
        logic [7:0] m;
    } rtcp_exp_t;

    localparam longint FAST_HZ = 64'd131072;
    localparam int PER0 = int'(FAST_HZ / 4096);
    localparam int PER1 = int'(FAST_HZ / 64);
    localparam int LIMIT = 60000;

    logic mclk = 1'b0;
    logic sys_rst;
    rtcp_pkg::rtcp_reg_req_t regReq;
    logic [7:0] regRdData;
    logic clkOutEnable;
    logic [1:0] clkOutSel;
    logic clkPinIn, clkPinOut, clkPinOe;
    logic irqPinOut, irqPinOe, secTick, countdownDone;
    logic rdTake, extClk;
    rtcp_exp_t expQ[$];
    rtcp_exp_t e;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int secCount = 0;
    int t0, t1, w, s0, r;
    logic [31:0] seed = 32'hEA24;
    logic [7:0] nv, a, b;

    always #10 mclk = ~mclk;
    // Pin wire: design drives unless in test mode
    assign clkPinIn = clkPinOe ? clkPinOut : extClk;

    rtcp_host host (.mclk(mclk), .regReq(regReq), .rdTake(rdTake), .extClk(extClk));

    rtcp_timer #(.CLK_HZ(FAST_HZ)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .regReq(regReq), .regRdData(regRdData),
        .clkOutEnable(clkOutEnable), .clkOutSel(clkOutSel), .clkPinIn(clkPinIn),
        .clkPinOut(clkPinOut), .clkPinOe(clkPinOe), .irqPinOut(irqPinOut),
        .irqPinOe(irqPinOe), .secTick(secTick), .countdownDone(countdownDone));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic rdx(input logic [3:0] ad, input logic [7:0] d, input logic [7:0] m);
        expQ.push_back('{d: d, m: m});
        host.rd(ad);
    endtask

    // Bounded wait for done (0) or interrupt pin (1)
    task automatic wait_hi(input int which, output int t);
        int n = 0;
        while ((which ? irqPinOe : countdownDone) !== 1'b1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 20000) failures++;
        t = cyc;
    endtask

    task automatic rises(input int n, output int k);
        logic p;
        k = 0;
        p = clkPinOut;
        repeat (n) begin
            @(negedge mclk);
            if (clkPinOut === 1'b1 && p !== 1'b1) k++;
            p = clkPinOut;
        end
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (secTick === 1'b1) secCount++;
        if (rdTake === 1'b1 && expQ.size() > 0) begin
            e = expQ.pop_front();
            check(16'(regRdData & e.m), 16'(e.d & e.m));
        end
        if (cyc == LIMIT) begin
            failures++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        clkOutEnable = 1'b1;
        clkOutSel = 2'h0;
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        rdx(rtcp_pkg::ADDR_CFG, 8'h03, 8'h83);
        rdx(rtcp_pkg::ADDR_CTRL2, 8'h00, 8'hFF);
        seed = lfsr(seed);
        host.wr(4'h5, seed[7:0]);
        rdx(4'h5, 8'h00, 8'hFF);
        for (int s = 0; s < 4; s++) begin
            host.wr(rtcp_pkg::ADDR_CFG, {6'h1F, 2'(s)});
            rdx(rtcp_pkg::ADDR_CFG, {6'h00, 2'(s)}, 8'hFF);
        end
        $display("end: reset and map");
        for (int s = 0; s < 2; s++) begin
            seed = lfsr(seed);
            nv = (s == 0) ? 8'(2 + seed[2:0]) : 8'h01;
            host.wr(rtcp_pkg::ADDR_CFG, 8'h00);
            host.wr(rtcp_pkg::ADDR_CTRL2, 8'h01);
            host.wr(rtcp_pkg::ADDR_VALUE, nv);
            host.wr(rtcp_pkg::ADDR_CFG, {6'h20, 2'(s)});
            wait_hi(0, t0);
            @(negedge mclk);
            check(16'({irqPinOe, irqPinOut}), 16'h2);
            host.wr(rtcp_pkg::ADDR_CTRL2, 8'h01);
            check(16'(countdownDone), 16'h0);
            wait_hi(0, t1);
            check(16'(t1 - t0), 16'(int'(nv) * (s ? PER1 : PER0)));
            repeat (3 * PER0) @(negedge mclk);
            check(16'(countdownDone), 16'h1);
        end
        $display("end: countdown periods");
        // Stop first so a stale pulse drains before pulse mode is chosen
        host.wr(rtcp_pkg::ADDR_CFG, 8'h00);
        repeat (2 * PER0) @(negedge mclk);
        host.wr(rtcp_pkg::ADDR_VALUE, 8'h03);
        host.wr(rtcp_pkg::ADDR_CTRL2, 8'h11);
        host.wr(rtcp_pkg::ADDR_CFG, 8'h80);
        wait_hi(1, t0);
        w = 0;
        while (irqPinOe === 1'b1 && w < 5000) begin
            @(negedge mclk);
            w++;
        end
        check(16'(w), 16'(PER0));
        check(16'(countdownDone), 16'h1);
        $display("end: pulsed interrupt");
        host.wr(rtcp_pkg::ADDR_VALUE, 8'hFF);
        host.rd(rtcp_pkg::ADDR_VALUE);
        // Two reads taken together, as a careful host would
        host.rd(rtcp_pkg::ADDR_VALUE);
        a = regRdData;
        repeat (200) @(negedge mclk);
        host.rd(rtcp_pkg::ADDR_VALUE);
        b = regRdData;
        check(16'((a - b == 8'h06) || (a - b == 8'h07)), 16'h1);
        host.wr(rtcp_pkg::ADDR_CFG, 8'h00);
        host.rd(rtcp_pkg::ADDR_VALUE);
        a = regRdData;
        repeat (100) @(negedge mclk);
        host.rd(rtcp_pkg::ADDR_VALUE);
        check(16'(regRdData), 16'(a));
        $display("end: live count");
        // Test bit, then halt set and clear to reach a known state
        host.wr(rtcp_pkg::ADDR_CTRL1, 8'h80);
        check(16'(clkPinOe), 16'h0);
        host.wr(rtcp_pkg::ADDR_CTRL1, 8'hA0);
        s0 = secCount;
        host.ticks(40, 16);
        check(16'(secCount - s0), 16'h0);
        // Countdown on the 1 Hz source, fed by pin seconds
        host.wr(rtcp_pkg::ADDR_CTRL2, 8'h01);
        host.wr(rtcp_pkg::ADDR_VALUE, 8'h02);
        host.wr(rtcp_pkg::ADDR_CFG, 8'h82);
        host.wr(rtcp_pkg::ADDR_CTRL1, 8'h80);
        host.ticks(31, 16);
        check(16'(secCount - s0), 16'h0);
        host.ticks(1, 30);
        check(16'(secCount - s0), 16'h1);
        check(16'(countdownDone), 16'h0);
        host.ticks(63, 16);
        check(16'(secCount - s0), 16'h1);
        host.ticks(1, 16);
        check(16'(secCount - s0), 16'h2);
        check(16'(countdownDone), 16'h1);
        $display("end: external tick mode");
        host.wr(rtcp_pkg::ADDR_CTRL1, 8'h20);
        for (int k = 0; k < 5; k++) begin
            if (k == 4) host.wr(rtcp_pkg::ADDR_CTRL1, 8'h00);
            clkOutSel = (k == 4) ? 2'h1 : 2'(k);
            rises(256, r);
            check(16'(k == 0 ? (r >= 63 && r <= 65) : k < 4 ? r == 0 : r >= 1 && r <= 3),
                16'h1);
        end
        host.wr(rtcp_pkg::ADDR_CFG, 8'h03);
        rdx(rtcp_pkg::ADDR_CFG, 8'h03, 8'hFF);
        $display("end: clock output under halt");
        close_out();
    end
endmodule // rtcp_timer_test
